/* File: common/mpt_pkg.sv */
package mpt_pkg;
  // Timing base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int HOUR_CS = 360000;
  localparam int TBS_UNIT_CS = 60;
  // Thresholds and ranges
  localparam int PTC_TRIP_OHMS = 2900;
  localparam int FREQ_VOLT_MIN_PCT = 50;
  localparam int AVAIL_MIN = -9;
  localparam int AVAIL_MAX = 10;
  localparam int SPH_SLOTS = 10;
  localparam int NTIMER = 12;
  localparam int NSPEED = 3;
  localparam int FULL_SPEED_BIT = 2;
  // Function indices for the enable masks
  localparam int FN_REVP = 0;
  localparam int FN_PFQ4 = 1;
  localparam int FN_PFQ3 = 2;
  localparam int FN_UFREQ = 3;
  localparam int FN_OFREQ = 4;
  localparam int FN_DIFF = 5;
  localparam int FN_SPH = 6;
  localparam int FN_SPEED = 7;
  localparam int FN_PTC = 8;
  localparam int FN_DCOM = 9;
  // Configuration bits
  localparam int CFG_SPEED_ANALOG_BIT = 0;
  localparam int CFG_DIFF_EN_BIT = 1;
  localparam int CFG_DCOM_CHK_BIT = 2;
  localparam int CFG_PTC_EN_BIT = 3;
  // Register byte offsets
  localparam logic [7:0] REG_LVL_BASE = 8'h00;
  localparam logic [7:0] REG_DLY_BASE = 8'h40;
  localparam logic [7:0] REG_TRIP_EN = 8'h80;
  localparam logic [7:0] REG_ALARM_EN = 8'h84;
  localparam logic [7:0] REG_CFG = 8'h88;
  localparam logic [7:0] REG_IPTH = 8'h8C;
  localparam logic [7:0] REG_SPH = 8'h90;
  localparam logic [7:0] REG_TBS = 8'h94;
  localparam logic [7:0] REG_SPD_BASE = 8'hA0;
  localparam logic [7:0] REG_TIM_BASE = 8'hB0;
  localparam logic [7:0] REG_STATUS = 8'hC0;
  localparam logic [7:0] REG_DISP = 8'hC4;
  // Reset values
  localparam logic [15:0] LVL_RST = 16'h0000;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [15:0] EN_RST = 16'h0000;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [15:0] IPTH_RST = 16'h000A;
  localparam logic [3:0] SPH_RST = 4'hA;
  localparam logic [15:0] TBS_RST = 16'h0000;
  localparam logic [15:0] SPD_RST = 16'h2710;
  localparam logic [16:0] TIM_RST = 17'h186A0;

  // Front-end measurements, fixed point in hundredths except voltPct (percent) and ptcOhms (ohms)
  typedef struct packed {
    logic signed [15:0] realPower;
    logic signed [15:0] reactivePower;
    logic [7:0] pfAbs;
    logic [15:0] currentRatio;
    logic runMode;
    logic motorCurrent;
    logic [15:0] freq;
    logic [7:0] voltPct;
    logic [15:0] tachSpeed;
    logic [15:0] analogSpeed;
    logic [15:0] diffCurrent;
    logic diffCommOk;
    logic [15:0] ptcOhms;
  } mpt_meas_t;

  // Thermal model status, remaining times
  typedef struct packed {
    logic [15:0] resetTime;
    logic [15:0] tripTime;
    logic [15:0] inhibitTime;
    logic inhibit;
  } mpt_thermal_t;

  typedef struct packed {
    logic [7:0] spare;
    logic ptcAlarm;
    logic dcomTrip;
    logic ptcTrip;
    logic underspeedTrip;
    logic accelTrip;
    logic fullSpeed;
    logic spAlarm;
    logic spTrip;
  } mpt_status_t;

  typedef enum logic [2:0] {DSP_RESET, DSP_TRIP, DSP_INHIB, DSP_SPH_INHIB, DSP_AVAIL} mpt_disp_t;
  typedef enum logic [1:0] {ACC_IDLE, ACC_STAGE, ACC_RUN, ACC_FAIL} mpt_acc_t;
endpackage

/* File: hdl/mpt_trip_logic.sv */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module mpt_trip_logic import mpt_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Front end and thermal model
  input wire mpt_meas_t meas,
  input wire mpt_thermal_t thermal,
  // Operator panel commands
  input wire logic resetCmd,
  input wire logic emergencyThermalClear,
  // Protection outputs
  output logic tripOutputOne,
  output logic alarmOutputOne,
  output logic startInhibit,
  output mpt_status_t statusWord,
  output mpt_disp_t dispSel,
  output logic [21:0] dispValue
);
  logic [31:0] tickCnt_q;
  logic tick_q;
  logic [15:0] lvl_q [NTIMER];
  logic [15:0] dly_q [NTIMER];
  logic [15:0] cnt_q [NTIMER];
  logic [15:0] tripEn_q, alarmEn_q, ipth_q, tbs_q;
  logic [3:0] cfg_q, sph_q;
  logic [15:0] spd_q [NSPEED];
  logic [16:0] tim_q [NSPEED];
  logic [NTIMER-1:0] cond, hit;
  logic [18:0] age_q [SPH_SLOTS];
  logic [SPH_SLOTS-1:0] valid_q;
  logic [21:0] sinceLast_q, tbsCs, tbsRem, hourRem, sphInhibit;
  logic sinceValid_q, motorPrev_q, startEdge, stopped, sphViol, tbsViol, viol;
  logic [3:0] startCount;
  logic signed [4:0] avail;
  logic spTrip_q, spAlarm_q, accelTrip_q, usTrip_q, fullSpeed_q;
  logic ptcTrip_q, ptcAlarm_q, ptcCond, dcomTrip_q, dcomAlarm_q, dcomLoss;
  mpt_acc_t accState_q;
  logic [1:0] stage_q;
  logic [16:0] accTime_q;
  logic [15:0] speed, revMag;
  logic pfActive, freqOk, emergency_thermal_clear;
  logic [31:0] rdMux;

  assign emergency_thermal_clear = emergencyThermalClear;

  // Ten millisecond timebase for every delay
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tickCnt_q >= 32'(TICK_CYC - 1)) begin
      tickCnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // Settings written by software; emergency clear drops thermistor enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NTIMER; i++) begin
        lvl_q[i] <= LVL_RST;
        dly_q[i] <= DLY_RST;
      end
      for (int i = 0; i < NSPEED; i++) begin
        spd_q[i] <= SPD_RST;
        tim_q[i] <= TIM_RST;
      end
      tripEn_q <= EN_RST;
      alarmEn_q <= EN_RST;
      cfg_q <= CFG_RST;
      ipth_q <= IPTH_RST;
      sph_q <= SPH_RST;
      tbs_q <= TBS_RST;
    end else begin
      if (regWr) begin
        if (regAddr[7:6] == REG_LVL_BASE[7:6] && regAddr[5:2] < 4'(NTIMER))
          lvl_q[regAddr[5:2]] <= regWdata[15:0];
        if (regAddr[7:6] == REG_DLY_BASE[7:6] && regAddr[5:2] < 4'(NTIMER))
          dly_q[regAddr[5:2]] <= regWdata[15:0];
        if (regAddr[7:4] == REG_SPD_BASE[7:4] && regAddr[3:2] < 2'(NSPEED))
          spd_q[regAddr[3:2]] <= regWdata[15:0];
        if (regAddr[7:4] == REG_TIM_BASE[7:4] && regAddr[3:2] < 2'(NSPEED))
          tim_q[regAddr[3:2]] <= regWdata[16:0];
        if (regAddr == REG_TRIP_EN) tripEn_q <= regWdata[15:0];
        if (regAddr == REG_ALARM_EN) alarmEn_q <= regWdata[15:0];
        if (regAddr == REG_CFG) cfg_q <= regWdata[3:0];
        if (regAddr == REG_IPTH) ipth_q <= regWdata[15:0];
        if (regAddr == REG_SPH) sph_q <= regWdata[3:0];
        if (regAddr == REG_TBS) tbs_q <= regWdata[15:0];
      end
      if (emergency_thermal_clear) cfg_q[CFG_PTC_EN_BIT] <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdMux = 32'h00000000;
    if (regAddr[7:6] == REG_LVL_BASE[7:6] && regAddr[5:2] < 4'(NTIMER))
      rdMux = {16'h0000, lvl_q[regAddr[5:2]]};
    else if (regAddr[7:6] == REG_DLY_BASE[7:6] && regAddr[5:2] < 4'(NTIMER))
      rdMux = {16'h0000, dly_q[regAddr[5:2]]};
    else if (regAddr[7:4] == REG_SPD_BASE[7:4] && regAddr[3:2] < 2'(NSPEED))
      rdMux = {16'h0000, spd_q[regAddr[3:2]]};
    else if (regAddr[7:4] == REG_TIM_BASE[7:4] && regAddr[3:2] < 2'(NSPEED))
      rdMux = {15'h0000, tim_q[regAddr[3:2]]};
    else if (regAddr == REG_TRIP_EN) rdMux = {16'h0000, tripEn_q};
    else if (regAddr == REG_ALARM_EN) rdMux = {16'h0000, alarmEn_q};
    else if (regAddr == REG_CFG) rdMux = {28'h0000000, cfg_q};
    else if (regAddr == REG_IPTH) rdMux = {16'h0000, ipth_q};
    else if (regAddr == REG_SPH) rdMux = {28'h0000000, sph_q};
    else if (regAddr == REG_TBS) rdMux = {16'h0000, tbs_q};
    else if (regAddr == REG_STATUS) rdMux = {16'h0000, statusWord};
    else if (regAddr == REG_DISP) rdMux = {7'h00, dispSel, dispValue};
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) regRdata <= 32'h00000000;
    else if (regRd) regRdata <= rdMux;
    else regRdata <= 32'h00000000;
  end

  // Level conditions; even index trip level, odd index alarm level
  always_comb begin
    revMag = meas.realPower[15] ? 16'(-meas.realPower) : 16'h0000;
    pfActive = meas.runMode && (meas.currentRatio >= ipth_q);
    freqOk = meas.voltPct >= 8'(FREQ_VOLT_MIN_PCT);
    for (int t = 0; t < 2; t++) begin
      cond[2*FN_REVP+t] = meas.realPower[15] && (revMag > lvl_q[2*FN_REVP+t]);
      cond[2*FN_PFQ4+t] = pfActive && meas.realPower > 16'sh0000 &&
        meas.reactivePower > 16'sh0000 && {8'h00, meas.pfAbs} < lvl_q[2*FN_PFQ4+t];
      cond[2*FN_PFQ3+t] = pfActive && meas.realPower < 16'sh0000 &&
        meas.reactivePower > 16'sh0000 && {8'h00, meas.pfAbs} < lvl_q[2*FN_PFQ3+t];
      cond[2*FN_UFREQ+t] = freqOk && (meas.freq < lvl_q[2*FN_UFREQ+t]);
      cond[2*FN_OFREQ+t] = freqOk && (meas.freq > lvl_q[2*FN_OFREQ+t]);
      cond[2*FN_DIFF+t] = cfg_q[CFG_DIFF_EN_BIT] && (meas.diffCurrent > lvl_q[2*FN_DIFF+t]);
    end
  end

  // One delay timer per level; zero delay acts at once
  for (genvar g = 0; g < NTIMER; g++) begin : gTimer
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) cnt_q[g] <= 16'h0000;
      else if (!cond[g]) cnt_q[g] <= 16'h0000;
      else if (tick_q && cnt_q[g] < dly_q[g]) cnt_q[g] <= cnt_q[g] + 16'h0001;
    end
    assign hit[g] = cond[g] && (cnt_q[g] >= dly_q[g]);
  end

  // Start history: slot 0 newest, slots age out after an hour
  assign startEdge = meas.motorCurrent && !motorPrev_q;
  assign stopped = !meas.motorCurrent;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      motorPrev_q <= 1'b0;
      valid_q <= '0;
      for (int i = 0; i < SPH_SLOTS; i++) age_q[i] <= 19'h00000;
    end else begin
      motorPrev_q <= meas.motorCurrent;
      if (emergency_thermal_clear) begin
        valid_q <= '0;
      end else if (startEdge) begin
        for (int i = SPH_SLOTS - 1; i > 0; i--) begin
          age_q[i] <= age_q[i-1];
          valid_q[i] <= valid_q[i-1];
        end
        age_q[0] <= 19'h00000;
        valid_q[0] <= 1'b1;
      end else if (tick_q) begin
        for (int i = 0; i < SPH_SLOTS; i++) begin
          if (age_q[i] >= 19'(HOUR_CS - 1)) valid_q[i] <= 1'b0;
          else age_q[i] <= age_q[i] + 19'h00001;
        end
      end
    end
  end

  // Time since last start, saturating
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sinceLast_q <= 22'h000000;
      sinceValid_q <= 1'b0;
    end else if (emergency_thermal_clear) begin
      sinceValid_q <= 1'b0;
    end else if (startEdge) begin
      sinceLast_q <= 22'h000000;
      sinceValid_q <= 1'b1;
    end else if (tick_q && sinceLast_q != 22'h3FFFFF) begin
      sinceLast_q <= sinceLast_q + 22'h000001;
    end
  end

  always_comb begin
    startCount = 4'h0;
    for (int i = 0; i < SPH_SLOTS; i++) startCount = startCount + {3'h0, valid_q[i]};
    tbsCs = 22'(tbs_q) * 22'(TBS_UNIT_CS);
    tbsViol = sinceValid_q && (sinceLast_q < tbsCs);
    sphViol = startCount >= sph_q;
    viol = sphViol || tbsViol;
    avail = $signed({1'b0, sph_q}) - $signed({1'b0, startCount});
    // clamp to shown range; odd settings stay displayable
    if (avail > 5'sh0A) avail = 5'sh0A;
    else if (avail < 5'sh17) avail = 5'sh17;
    tbsRem = tbsViol ? tbsCs - sinceLast_q : 22'h000000;
    hourRem = 22'h000000;
    if (sphViol && sph_q != 4'h0)
      hourRem = 22'(HOUR_CS) - {3'h0, age_q[sph_q - 4'h1]};
    sphInhibit = (hourRem > tbsRem) ? hourRem : tbsRem;
  end

  // Start limit trip and alarm
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      spTrip_q <= 1'b0;
      spAlarm_q <= 1'b0;
    end else begin
      spAlarm_q <= stopped && viol && alarmEn_q[FN_SPH] && !emergency_thermal_clear;
      if (emergency_thermal_clear) spTrip_q <= 1'b0;
      else if (stopped && viol && tripEn_q[FN_SPH]) spTrip_q <= 1'b1;
      else if (resetCmd) spTrip_q <= 1'b0;
    end
  end

  assign speed = cfg_q[CFG_SPEED_ANALOG_BIT] ? meas.analogSpeed : meas.tachSpeed;

  // Acceleration supervision; cumulative time from the start edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      accState_q <= ACC_IDLE;
      stage_q <= 2'h0;
      accTime_q <= 17'h00000;
    end else begin
      if (tick_q && accTime_q != 17'h1FFFF) accTime_q <= accTime_q + 17'h00001;
      case (accState_q)
        ACC_IDLE: begin
          if (startEdge && tripEn_q[FN_SPEED]) begin
            accState_q <= ACC_STAGE;
            stage_q <= 2'h0;
            accTime_q <= 17'h00000;
          end
        end
        ACC_STAGE: begin
          if (stopped) accState_q <= ACC_IDLE;
          else if (speed >= spd_q[stage_q]) begin
            if (stage_q == 2'(NSPEED - 1)) accState_q <= ACC_RUN;
            else stage_q <= stage_q + 2'h1;
          end else if (accTime_q >= tim_q[stage_q]) accState_q <= ACC_FAIL;
        end
        ACC_RUN: if (stopped) accState_q <= ACC_IDLE;
        ACC_FAIL: if (stopped) accState_q <= ACC_IDLE;
        default: accState_q <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      accelTrip_q <= 1'b0;
      usTrip_q <= 1'b0;
      fullSpeed_q <= 1'b0;
    end else begin
      fullSpeed_q <= tripEn_q[FN_SPEED] && (speed > spd_q[NSPEED-1]);
      if (accState_q == ACC_STAGE && !stopped && speed < spd_q[stage_q] &&
          accTime_q >= tim_q[stage_q])
        accelTrip_q <= 1'b1;
      else if (resetCmd) accelTrip_q <= 1'b0;
      if (accState_q == ACC_RUN && !stopped && speed < spd_q[NSPEED-1])
        usTrip_q <= 1'b1;
      else if (resetCmd) usTrip_q <= 1'b0;
    end
  end

  assign dcomLoss = cfg_q[CFG_DIFF_EN_BIT] && cfg_q[CFG_DCOM_CHK_BIT] && !meas.diffCommOk;
  assign ptcCond = cfg_q[CFG_PTC_EN_BIT] && (meas.ptcOhms > 16'(PTC_TRIP_OHMS));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dcomTrip_q <= 1'b0;
      dcomAlarm_q <= 1'b0;
      ptcTrip_q <= 1'b0;
      ptcAlarm_q <= 1'b0;
    end else begin
      dcomTrip_q <= dcomLoss && tripEn_q[FN_DCOM];
      dcomAlarm_q <= dcomLoss && alarmEn_q[FN_DCOM];
      ptcAlarm_q <= ptcCond && alarmEn_q[FN_PTC] && !emergency_thermal_clear;
      if (emergency_thermal_clear) ptcTrip_q <= 1'b0;
      else if (ptcCond && tripEn_q[FN_PTC]) ptcTrip_q <= 1'b1;
      else if (resetCmd) ptcTrip_q <= 1'b0;
    end
  end

  // Output merge; timer results gated by enables
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tripOutputOne <= 1'b0;
      alarmOutputOne <= 1'b0;
      startInhibit <= 1'b0;
    end else begin
      tripOutputOne <= |({hit[10], hit[8], hit[6], hit[4], hit[2], hit[0]} & tripEn_q[5:0])
        || spTrip_q || accelTrip_q || usTrip_q || ptcTrip_q || dcomTrip_q;
      alarmOutputOne <= |({hit[11], hit[9], hit[7], hit[5], hit[3], hit[1]} & alarmEn_q[5:0])
        || spAlarm_q || ptcAlarm_q || dcomAlarm_q;
      startInhibit <= spTrip_q || spAlarm_q || thermal.inhibit;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dispSel <= DSP_AVAIL;
      dispValue <= 22'h000000;
    end else if (thermal.resetTime != 16'h0000) begin
      dispSel <= DSP_RESET;
      dispValue <= {6'h00, thermal.resetTime};
    end else if (thermal.tripTime != 16'h0000) begin
      dispSel <= DSP_TRIP;
      dispValue <= {6'h00, thermal.tripTime};
    end else if (thermal.inhibitTime != 16'h0000) begin
      dispSel <= DSP_INHIB;
      dispValue <= {6'h00, thermal.inhibitTime};
    end else if (spTrip_q || spAlarm_q) begin
      dispSel <= DSP_SPH_INHIB;
      dispValue <= sphInhibit;
    end else begin
      dispSel <= DSP_AVAIL;
      dispValue <= {{17{avail[4]}}, avail};
    end
  end

  assign statusWord = '{spare: 8'h00, ptcAlarm: ptcAlarm_q, dcomTrip: dcomTrip_q,
    ptcTrip: ptcTrip_q, underspeedTrip: usTrip_q, accelTrip: accelTrip_q,
    fullSpeed: fullSpeed_q, spAlarm: spAlarm_q, spTrip: spTrip_q};

  // Checks
  sequence seqStart;
    startEdge && tripEn_q[FN_SPEED] && accState_q == ACC_IDLE;
  endsequence
  sequence seqStage0;
    accState_q == ACC_STAGE && stage_q == 2'h0 && accTime_q == 17'h00000;
  endsequence
  AST_ACC_START: assert property (@(posedge mclk) disable iff (!rstn)
    seqStart |=> seqStage0) else $error("start did not enter first stage");
  AST_INHIBIT: assert property (@(posedge mclk) disable iff (!rstn)
    (spTrip_q || spAlarm_q) |=> startInhibit) else $error("start inhibit missing");
  AST_LATCH: assert property (@(posedge mclk) disable iff (!rstn)
    (spTrip_q && !resetCmd && !emergency_thermal_clear) |=> spTrip_q) else $error("start trip dropped");
  AST_RUN_NOALARM: assert property (@(posedge mclk) disable iff (!rstn)
    meas.motorCurrent |=> !spAlarm_q) else $error("start alarm while running");
  AST_ETR: assert property (@(posedge mclk) disable iff (!rstn)
    emergency_thermal_clear |=> !spTrip_q && !ptcTrip_q && valid_q == '0) else $error("emergency clear failed");
  AST_FREQ_BLOCK: assert property (@(posedge mclk) disable iff (!rstn)
    !freqOk |=> cnt_q[2*FN_UFREQ] == 16'h0000 && cnt_q[2*FN_OFREQ] == 16'h0000)
    else $error("frequency timer ran at low voltage");
  AST_RESTART: assert property (@(posedge mclk) disable iff (!rstn)
    (cnt_q[0] != 16'h0000 && !cond[0]) |=> cnt_q[0] == 16'h0000)
    else $error("delay timer did not restart");
  AST_FULL: assert property (@(posedge mclk) disable iff (!rstn)
    statusWord[FULL_SPEED_BIT] |-> $past(tripEn_q[FN_SPEED]) && $past(speed) > $past(spd_q[2]))
    else $error("full speed flag without cause");
  AST_PTC: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(ptcTrip_q) |-> $past(meas.ptcOhms) > 16'(PTC_TRIP_OHMS))
    else $error("thermistor trip below limit");
  AST_AVAIL: assert property (@(posedge mclk) disable iff (!rstn)
    dispSel == DSP_AVAIL |-> $signed(dispValue) >= AVAIL_MIN && $signed(dispValue) <= AVAIL_MAX)
    else $error("available starts out of range");
  AST_DISP: assert property (@(posedge mclk) disable iff (!rstn)
    thermal.resetTime != 16'h0000 |=> dispSel == DSP_RESET) else $error("display priority");
endmodule

/* File: sim/mpt_front_end.sv */
`timescale 1ns/100ps
module mpt_front_end import mpt_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Plant state and its metered copy
  input wire mpt_meas_t plant,
  output mpt_meas_t meas
);
  // One update of lag, so the relay never sees the plant early
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meas <= '0;
    end else begin
      meas <= plant;
    end
  end
endmodule

/* File: sim/motor_protection_trip_logic_test.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module motor_protection_trip_logic_test import mpt_pkg::*;;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic regWr = 1'b0, regRd = 1'b0, resetCmd = 1'b0, emergencyThermalClear = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic [31:0] regRdata;
  logic tripOutputOne, alarmOutputOne, startInhibit;
  logic [21:0] dispValue;
  mpt_status_t statusWord;
  mpt_disp_t dispSel;
  mpt_meas_t plant = '0;
  mpt_meas_t meas;
  // Thermal model is out of scope, held quiet until the display priority check
  mpt_thermal_t thermal = '0;
  logic [27:0] row [6];
  int errors = 0;
  int num_checks = 0;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  mpt_front_end FE (.mclk(mclk), .rstn(rstn), .plant(plant), .meas(meas));
  // Short tick keeps every delay a few tens of cycles
  mpt_trip_logic #(.TICK_CYC(10)) DUT (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .meas(meas),
    .thermal(thermal), .resetCmd(resetCmd), .emergencyThermalClear(emergencyThermalClear),
    .tripOutputOne(tripOutputOne), .alarmOutputOne(alarmOutputOne),
    .startInhibit(startInhibit), .statusWord(statusWord), .dispSel(dispSel),
    .dispValue(dispValue));

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Register read, data only in the following cycle
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    `CHK(regRdata, e)
  endtask

  // Wait n edges, then sample mid-cycle where outputs are settled
  task automatic mid(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  // One-cycle reset command or emergency clear
  task automatic pulse(input logic clr);
    @(posedge mclk);
    {emergencyThermalClear, resetCmd} <= {clr, !clr};
    @(posedge mclk);
    {emergencyThermalClear, resetCmd} <= 2'b00;
  endtask

  // Verdict and end of run
  task automatic final_report;
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog, several times the expected run length
  initial begin
    mid(6000);
    errors++;
    final_report;
  end

  initial begin
    mid(4);
    @(posedge mclk);
    rstn <= 1'b1;
    mid(2);
    `CHK(dispSel, DSP_AVAIL)
    `CHK(dispValue, 22'h00000A)
    rchk(REG_SPH, 32'h0000000A);
    // acceleration times stay at equal defaults
    rchk(REG_TIM_BASE + 8'h08, 32'h000186A0);
    rchk(8'hFC, 32'h00000000);
    // Reverse power 0.10 pu over 3 ticks, trip only
    wr(REG_LVL_BASE, 32'h0000000A);
    wr(REG_DLY_BASE, 32'h00000003);
    wr(REG_TRIP_EN, 32'h00000001);
    @(posedge mclk);
    plant.realPower <= 16'hFFCE;
    mid(15);
    `CHK(tripOutputOne, 1'b0)
    mid(25);
    `CHK(({tripOutputOne, alarmOutputOne}), 2'b10)
    @(posedge mclk);
    plant.realPower <= 16'h0032;
    mid(4);
    `CHK(tripOutputOne, 1'b0)
    @(posedge mclk);
    plant.realPower <= 16'hFFF7;
    mid(50);
    `CHK(tripOutputOne, 1'b0)
    // Frequency window 50.00 to 55.00 Hz, zero delay; rows {trip, volt, freq}
    wr(8'h18, 32'h00001388);
    wr(8'h20, 32'h0000157C);
    wr(REG_TRIP_EN, 32'h00000018);
    row = '{28'h0281194, 28'h13C1194, 28'h0321388, 28'h1321770, 28'h03C1450, 28'h0281770};
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      plant.voltPct <= row[i][23:16];
      plant.freq <= row[i][15:0];
      mid(4);
      `CHK(tripOutputOne, row[i][24])
    end
    // Power factor 0.90 forward, 0.70 reverse; rows {trip, run, current, pf, negative}
    wr(8'h08, 32'h0000005A);
    wr(8'h10, 32'h00000046);
    wr(REG_TRIP_EN, 32'h00000006);
    row = '{28'h0014500, 28'h0109500, 28'h110A500, 28'h01145A0, 28'h0114501, 28'h11143C1};
    @(posedge mclk);
    plant.reactivePower <= 16'h0064;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      plant.runMode <= row[i][20];
      plant.currentRatio <= {8'h00, row[i][19:12]};
      plant.pfAbs <= row[i][11:4];
      plant.realPower <= row[i][0] ? 16'hFF9C : 16'h0064;
      mid(4);
      `CHK(tripOutputOne, row[i][24])
    end
    // Start limit at one start per hour, trip and alarm
    @(posedge mclk);
    plant <= '0;
    wr(REG_SPH, 32'h00000001);
    wr(REG_TRIP_EN, 32'h00000040);
    wr(REG_ALARM_EN, 32'h00000040);
    @(posedge mclk);
    plant.motorCurrent <= 1'b1;
    mid(3);
    `CHK(statusWord[1:0], 2'b00)
    @(posedge mclk);
    plant.motorCurrent <= 1'b0;
    mid(3);
    `CHK(({statusWord[1:0], startInhibit, tripOutputOne}), 4'hF)
    `CHK(dispSel, DSP_SPH_INHIB)
    pulse(1'b0);
    mid(2);
    `CHK(statusWord.spTrip, 1'b1)
    // Running motor lifts the alarm and lets the trip reset
    @(posedge mclk);
    plant.motorCurrent <= 1'b1;
    mid(3);
    pulse(1'b0);
    mid(2);
    `CHK(({statusWord[1:0], startInhibit, tripOutputOne}), 4'h0)
    @(posedge mclk);
    plant.motorCurrent <= 1'b0;
    mid(3);
    `CHK(statusWord.spTrip, 1'b1)
    pulse(1'b1);
    mid(3);
    `CHK(({statusWord[1:0], dispSel}), ({2'b00, DSP_AVAIL}))
    `CHK(dispValue, 22'h000001)
    // Differential over level, link loss, thermistor
    wr(REG_ALARM_EN, 32'h00000200);
    wr(REG_CFG, 32'h0000000F);
    wr(8'h28, 32'h00000064);
    wr(REG_TRIP_EN, 32'h00000120);
    @(posedge mclk);
    plant.diffCurrent <= 16'h00C8;
    mid(4);
    `CHK(({tripOutputOne, alarmOutputOne}), 2'b11)
    @(posedge mclk);
    plant.diffCurrent <= 16'h0000;
    plant.diffCommOk <= 1'b1;
    plant.ptcOhms <= 16'h0BB8;
    mid(4);
    `CHK(({statusWord.ptcTrip, alarmOutputOne}), 2'b10)
    pulse(1'b1);
    mid(3);
    `CHK(({statusWord.ptcTrip, tripOutputOne}), 2'b00)
    rchk(REG_CFG, 32'h00000007);
    // Acceleration stages, analog speed selected
    wr(REG_TIM_BASE, 32'h00000002);
    wr(REG_TIM_BASE + 8'h04, 32'h00000003);
    wr(REG_TIM_BASE + 8'h08, 32'h00000004);
    wr(REG_SPD_BASE, 32'h000003E8);
    wr(REG_SPD_BASE + 8'h04, 32'h000007D0);
    wr(REG_SPD_BASE + 8'h08, 32'h00000BB8);
    wr(REG_TRIP_EN, 32'h00000080);
    @(posedge mclk);
    plant.motorCurrent <= 1'b1;
    mid(60);
    `CHK(({statusWord.accelTrip, tripOutputOne}), 2'b11)
    @(posedge mclk);
    plant.motorCurrent <= 1'b0;
    mid(3);
    pulse(1'b0);
    mid(2);
    `CHK(tripOutputOne, 1'b0)
    @(posedge mclk);
    plant.tachSpeed <= 16'h0FA0;
    plant.analogSpeed <= 16'h0DAC;
    plant.motorCurrent <= 1'b1;
    mid(6);
    `CHK(({statusWord.fullSpeed, tripOutputOne}), 2'b10)
    @(posedge mclk);
    plant.analogSpeed <= 16'h09C4;
    mid(4);
    `CHK(({statusWord.underspeedTrip, statusWord.fullSpeed, tripOutputOne}), 3'b101)
    // Thermal times take display priority
    @(posedge mclk);
    thermal <= '{resetTime: 16'h0005, tripTime: 16'h0007, inhibitTime: 16'h0000, inhibit: 1'b1};
    mid(3);
    `CHK(({dispSel, dispValue}), ({DSP_RESET, 22'h000005}))
    `CHK(startInhibit, 1'b1)
    @(posedge mclk);
    thermal.resetTime <= 16'h0000;
    mid(3);
    `CHK(({dispSel, dispValue}), ({DSP_TRIP, 22'h000007}))
    final_report;
  end
endmodule
